// >>> bench/cpu_priority_interrupt_system_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "prio_int_regs.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
// ========================================
// Bench for the priority interrupt block
module cpu_priority_interrupt_system_tb;
  localparam int SLOTS = 4;
  logic        clk = 1'h0, rst_n, done = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        fetch = 1'h0, xfer = 1'h0, kick = 1'h0, e, ack, pready, pslverr, lsw, spc, abt, hold, panel;
  logic [1:0]  ring = 2'h0, s;
  logic [3:0]  ext = 4'h0, lvl, sclr;
  logic [7:0]  paddr = 8'h00, dly = 8'h02, flt = 8'h00;
  logic [15:0] zflags = 16'h0000, raise = 16'h0000, sreq;
  logic [17:0] faddr = 18'h00000;
  logic [31:0] pwdata = 32'h0, q, prdata;
  logic [63:0] codes;
  int          err_count = 0, checks = 0;
  prio_int_system #(.SLOTS(SLOTS)) prio_int_system_inst (
    .REF_CLK_IN(clk), .ARST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PRDATA_OUT(prdata),
    .INSTR_DONE_IN(done), .FETCH_CYCLE_IN(fetch), .RING_IN(ring), .PRIV_OP_IN(flt[7]),
    .MONITOR_CALL_IN(flt[0]), .PROTECT_VIOLATION_IN(flt[1]), .PAGE_FAULT_IN(flt[2]),
    .ILLEGAL_OP_FAULT_IN(flt[3]), .MEMORY_RANGE_FAULT_IN(flt[4]), .PARITY_FAULT_IN(flt[5]),
    .POWER_FAIL_EVENT_IN(flt[6]), .FAULT_ADDRESS_IN(faddr), .FAULT_DETAIL_IN(8'h5A),
    .STATUS_ERROR_FLAGS_IN(zflags), .IO_TRANSFER_START_IN(xfer), .IO_ACK_IN(ack), .EXT_REQUEST_IN(ext),
    .SLOT_IDENT_CODE_IN(codes), .SLOT_REQUEST_IN(sreq), .SLOT_CLEAR_OUT(sclr), .CURRENT_LEVEL_OUT(lvl),
    .LEVEL_SWITCH_OUT(lsw), .SAVE_PC_OUT(spc), .ABORT_INSTR_OUT(abt), .PC_HOLD_OUT(hold),
    .PANEL_INDICATOR_OUT(panel));
  io_slot_model #(.SLOTS(SLOTS)) io_slot_model_inst (.clk_in(clk), .rst_n_in(rst_n), .raise_in(raise),
    .clear_in(sclr), .start_in(kick), .ack_delay_in(dly), .request_out(sreq), .code_out(codes), .ack_out(ack));
  initial forever #50 clk = ~clk;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1 && ++n < 20);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    if (n >= 20) err_count++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    apb(1'h0, a, 32'h0);
    `CHK(q[15:0], x)
  endtask
  task automatic rc(input logic [3:0] c);
    rd(`REG_INTERNAL_CAUSE_CODE, {12'h000, c});
  endtask
  // Fault held one cycle; abort and counter hold collected over the next three
  task automatic fire(input logic [7:0] f, input logic fc);
    s = 2'h0;
    @(posedge clk);
    {flt, fetch} <= {f, fc};
    @(posedge clk);
    {flt, fetch} <= 9'h000;
    repeat (3)
    begin
      @(negedge clk);
      s = s | {abt, hold};
    end
  endtask
  task automatic kick_io(input logic [7:0] d, input logic x);
    @(posedge clk);
    {dly, xfer, kick} <= {d, x, 1'h1};
    @(posedge clk);
    {xfer, kick} <= 2'h0;
    repeat (80) @(posedge clk);
  endtask
  task automatic t_reset_lock;
    rd(`REG_LEVEL_ENABLE_MASK, 16'h0000);
    rd(`REG_LEVEL_REQUEST_LATCH, 16'h0000);
    rd(`REG_CURRENT_LEVEL, 16'h0000);
    apb(1'h0, 8'h40, 32'h0);
    `CHK({e, q}, 33'h100000000)
    wr(`REG_LEVEL_ENABLE_MASK, 32'h4000);
    wr(`REG_INTERNAL_SRC_ENABLE, 32'h07DE);
    wr(`REG_CONTROL, 32'h3);
    fire(8'h08, 1'h0);
    rc(4'h0);
    rd(`REG_PARITY_FAULT_ADDRESS, 16'h0000);
    fire(8'h08, 1'h0);
    `CHK(s[1], 1'h1)
    rc(`CAUSE_ILLEGAL_OP);
    `CHK(lvl, `INTERNAL_LEVEL)
  endtask
  task automatic t_page;
    fire(8'h04, 1'h1);
    `CHK(s, 2'h3)
    rc(`CAUSE_PAGE_FAULT);
    fire(8'h04, 1'h0);
    `CHK(s, 2'h2)
    fire(8'h08, 1'h0);
    rc(`CAUSE_PAGE_FAULT);
  endtask
  task automatic t_priv;
    wr(`REG_CONTROL, 32'h1);
    fire(8'h80, 1'h0);
    `CHK(s[1], 1'h0)
    fire(8'h02, 1'h0);
    `CHK(s[1], 1'h0)
    wr(`REG_CONTROL, 32'h3);
    ring <= 2'h2;
    fire(8'h80, 1'h0);
    `CHK(s[1], 1'h0)
    fire(8'h02, 1'h1);
    `CHK(s, 2'h3)
    rc(`CAUSE_PROTECT_VIOLATION);
    ring <= 2'h1;
    fire(8'h80, 1'h0);
    rc(`CAUSE_PRIVILEGED_OP);
  endtask
  task automatic t_errflag;
    zflags <= 16'h0010;
    repeat (4) @(posedge clk);
    rc(`CAUSE_PRIVILEGED_OP);
    zflags <= 16'h0000;
    wr(`REG_INTERNAL_SRC_ENABLE, 32'h07FE);
    zflags <= 16'h0010;
    repeat (4) @(posedge clk);
    rc(`CAUSE_ERROR_FLAG);
    fire(8'h48, 1'h0);
    rc(`CAUSE_POWER_FAIL);
  endtask
  // Monitor call waits for the instruction end, unlike the aborting causes
  task automatic t_wait;
    {done, flt} <= {1'h0, 8'h01};
    repeat (3) @(posedge clk);
    rc(`CAUSE_POWER_FAIL);
    done <= 1'h1;
    @(posedge clk);
    flt <= 8'h00;
    rc(`CAUSE_MONITOR_CALL);
  endtask
  task automatic t_memory;
    faddr <= 18'h2ABCD;
    fire(8'h20, 1'h1);
    `CHK(s, 2'h0)
    rc(`CAUSE_PARITY);
    rd(`REG_PARITY_FAULT_STATUS, 16'h016A);
    rd(`REG_PARITY_FAULT_ADDRESS, 16'hABCD);
    faddr <= 18'h11234;
    fire(8'h10, 1'h1);
    `CHK(s, 2'h3)
    rc(`CAUSE_MEMORY_RANGE);
    rd(`REG_PARITY_FAULT_ADDRESS, 16'h1234);
    kick_io(8'h02, 1'h1);
    rc(`CAUSE_MEMORY_RANGE);
    kick_io(8'hFF, 1'h1);
    rc(`CAUSE_IO_TIMEOUT);
  endtask
  task automatic ident(input logic [15:0] code, input logic [3:0] slot);
    wr(`REG_COMMAND, 32'h81);
    @(negedge clk);
    `CHK(sclr, slot)
    kick_io(8'h02, 1'h0);
    rd(`REG_IDENT_RESULT, code);
  endtask
  task automatic t_ident;
    raise <= 16'h0220;
    @(posedge clk);
    raise <= 16'h0000;
    ident(16'h0A02, 4'h2);
    ident(16'h0A03, 4'h4);
    ident(16'h0000, 4'h0);
  endtask
  task automatic t_levels;
    wr(`REG_LEVEL_ENABLE_MASK, 32'h5000);
    ext <= 4'h4;
    @(posedge clk);
    ext <= 4'h0;
    rd(`REG_LEVEL_REQUEST_LATCH, 16'h5000);
    `CHK(lvl, 4'hE)
    wr(`REG_COMMAND, 32'h4);
    @(negedge clk);
    `CHK({spc, lsw}, 2'h2)
    @(negedge clk);
    `CHK({spc, lsw}, 2'h3)
    `CHK(lvl, 4'hC)
    rd(`REG_LEVEL_REQUEST_LATCH, 16'h1000);
    wr(`REG_COMMAND, 32'h2);
    wr(`REG_LEVEL_ENABLE_MASK, 32'h7000);
    ext <= 4'h8;
    @(posedge clk);
    ext <= 4'h0;
    repeat (3) @(posedge clk);
    `CHK({panel, lvl}, 5'h0C)
    wr(`REG_COMMAND, 32'h1);
    repeat (3) @(posedge clk);
    `CHK({panel, lvl}, 5'h1D)
    wr(`REG_COMMAND, 32'h4);
    repeat (3) @(posedge clk);
    `CHK(lvl, 4'hC)
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    rst_n <= 1'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    t_reset_lock;
    t_page;
    t_priv;
    t_errflag;
    t_wait;
    t_memory;
    t_ident;
    t_levels;
    report_and_stop;
  end
  // Whole run is near 650 cycles; give it more than seven times that
  initial
  begin
    #500000;
    err_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire

// >>> bench/io_slot_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Device interfaces on the I/O bus
module io_slot_model #(
  parameter int SLOTS = 4
)(
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic [SLOTS*4-1:0]  raise_in,
  input  wire logic [SLOTS-1:0]    clear_in,
  input  wire logic                start_in,
  input  wire logic [7:0]          ack_delay_in,
  output var  logic [SLOTS*4-1:0]  request_out,
  output var  logic [SLOTS*16-1:0] code_out,
  output var  logic                ack_out
);
  logic [7:0] cnt;
  logic       busy;
  // Arbitrary nonzero codes, so a zero result can only mean nobody answered
  always_comb
    for (int s = 0; s < SLOTS; s++)
      code_out[s*16 +: 16] = 16'h0A01 + 16'(s);
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      request_out <= '0;
      busy        <= 1'h0;
      cnt         <= 8'h00;
      ack_out     <= 1'h0;
    end
    else
    begin
      // A found interface drops its request; raises are held until found
      for (int s = 0; s < SLOTS; s++)
        request_out[s*4 +: 4] <= (clear_in[s] ? 4'h0 : request_out[s*4 +: 4]) | raise_in[s*4 +: 4];
      // Delay FF never answers, which is how a missing card is mimicked
      ack_out <= busy && cnt == 8'h00 && !start_in;
      busy    <= start_in || (busy && cnt != 8'h00);
      cnt     <= start_in ? ack_delay_in : cnt - ((cnt != 8'h00 && ack_delay_in != 8'hFF) ? 8'h01 : 8'h00);
    end
endmodule
`default_nettype wire

// >>> bench/prio_int_system_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Port checker
module prio_int_checker #(
  parameter int SLOTS = 4
)(
  input wire logic               REF_CLK_IN,
  input wire logic               ARST_N_IN,
  input wire logic               PSEL_IN,
  input wire logic               PENABLE_IN,
  input wire logic               PWRITE_IN,
  input wire logic               INSTR_DONE_IN,
  input wire logic               FETCH_CYCLE_IN,
  input wire logic [SLOTS*4-1:0] SLOT_REQUEST_IN,
  input wire logic [SLOTS-1:0]   SLOT_CLEAR_OUT,
  input wire logic [3:0]         CURRENT_LEVEL_OUT,
  input wire logic               LEVEL_SWITCH_OUT,
  input wire logic               ABORT_INSTR_OUT,
  input wire logic               PC_HOLD_OUT,
  input wire logic               PANEL_INDICATOR_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // A locked cause register forbids a second abort right behind the first
  sequence s_abort_once;
    ABORT_INSTR_OUT ##1 !ABORT_INSTR_OUT;
  endsequence
  a_reset_clears:
    assert property (disable iff (1'h0) !ARST_N_IN |-> CURRENT_LEVEL_OUT == 4'h0 && !PANEL_INDICATOR_OUT)
    else $error("level or panel set in reset");
  a_abort_once:
    assert property (ABORT_INSTR_OUT |-> s_abort_once)
    else $error("abort repeated while cause locked");
  a_hold_in_fetch:
    assert property (PC_HOLD_OUT |-> ABORT_INSTR_OUT && $past(FETCH_CYCLE_IN))
    else $error("counter hold outside a fetch abort");
  a_switch_at_end:
    assert property (LEVEL_SWITCH_OUT |-> $past(INSTR_DONE_IN))
    else $error("level switch mid-instruction");
  a_level_held:
    assert property (!$past(INSTR_DONE_IN) |-> $stable(CURRENT_LEVEL_OUT))
    else $error("level moved mid-instruction");
  a_panel_by_op:
    assert property ($changed(PANEL_INDICATOR_OUT) |-> $past(PSEL_IN && PENABLE_IN && PWRITE_IN))
    else $error("panel changed without a command");
  a_clear_one_slot:
    assert property ($onehot0(SLOT_CLEAR_OUT))
    else $error("more than one slot cleared");
  a_clear_needs_req:
    assert property (|SLOT_CLEAR_OUT |-> $past(|SLOT_REQUEST_IN))
    else $error("slot cleared with no request");
endmodule
bind prio_int_system prio_int_checker #(.SLOTS(SLOTS)) prio_int_checker_inst (
  .REF_CLK_IN, .ARST_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .INSTR_DONE_IN, .FETCH_CYCLE_IN,
  .SLOT_REQUEST_IN, .SLOT_CLEAR_OUT, .CURRENT_LEVEL_OUT, .LEVEL_SWITCH_OUT, .ABORT_INSTR_OUT,
  .PC_HOLD_OUT, .PANEL_INDICATOR_OUT);
`default_nettype wire

// >>> common/prio_int_regs.vh
`ifndef PRIO_INT_REGS_VH
`define PRIO_INT_REGS_VH
// ==========================================
// Register map (APB byte addresses)
`define REG_LEVEL_ENABLE_MASK    8'h00
`define REG_LEVEL_REQUEST_LATCH  8'h04
`define REG_CURRENT_LEVEL        8'h08
`define REG_INTERNAL_SRC_ENABLE  8'h0C
`define REG_INTERNAL_CAUSE_CODE  8'h10
`define REG_PARITY_FAULT_ADDRESS 8'h14
`define REG_PARITY_FAULT_STATUS  8'h18
`define REG_CONTROL              8'h1C
`define REG_STATUS               8'h20
`define REG_IDENT_RESULT         8'h24
`define REG_COMMAND              8'h28
// ==========================================
// Cause codes (octal values)
`define CAUSE_MONITOR_CALL       4'h1
`define CAUSE_PROTECT_VIOLATION  4'h2
`define CAUSE_PAGE_FAULT         4'h3
`define CAUSE_ILLEGAL_OP         4'h4
`define CAUSE_ERROR_FLAG         4'h5
`define CAUSE_PRIVILEGED_OP      4'h6
`define CAUSE_IO_TIMEOUT         4'h7
`define CAUSE_PARITY             4'h8
`define CAUSE_MEMORY_RANGE       4'h9
`define CAUSE_POWER_FAIL         4'hA
// ==========================================
// Field positions and constants
`define INTERNAL_LEVEL           4'hE
`define ERROR_FLAG_BIT           3
`define CTRL_SYSTEM_ON_BIT       0
`define CTRL_PAGING_ON_BIT       1
`define CMD_TURN_ON_BIT          0
`define CMD_TURN_OFF_BIT         1
`define CMD_GIVE_UP_BIT          2
`define CMD_IDENTIFY_BIT         3
`define CLK_PERIOD_NS            100
`define IO_ACK_TIMEOUT_NS        6000
`define IO_ACK_TIMEOUT_CYCLES    (`IO_ACK_TIMEOUT_NS / `CLK_PERIOD_NS)
`endif

// >>> rtl/prio_int_system.v
// Operation
// - Page not present posts cause 3.
// - Unimplemented instruction posts cause 4.
// - Error flag set in any level status word posts cause 5.
// - Privileged operation from ring 0 or 1 posts cause 6.
// - No acknowledge within 6 us of identify or transfer posts cause 7.
// - Parity fault posts cause 10, captures address and status.
// - Non-existing memory access posts memory-range cause and captures fault info.
// - No priority among causes except power fail, which wins; the code checks the other causes in a fixed order.
// - Internal interrupt needs system on, level 14 enabled, source enabled.
// - Protect, page and privileged causes only while paging is on.
// - Some causes abort mid-instruction; others wait for instruction end.
// - Range, page, protect faults in fetch leave counter unincremented.
// - Power-up clears request latch, enable mask and current level.
// - Cause and fault registers start locked; reads unlock them.
// - Error flag source enabled by enable bit 5; flag is status bit 3.
// - Turn-on enables switching, moves to highest pending level, lights indicator.
// - Turn-off stops switching, keeps level, darkens indicator.
// - External interrupts use levels 10 through 13.
// - Identify searches level; first interface returns code and clears request.
// - Higher level wins; leftmost interface on a level found first.
// - Give-up clears own request bit; moves to highest remaining level.
// - Highest pending enabled level compared to current; switch on mismatch.
// - Captured cause code locks until software reads it.
`timescale 1ns/1ps
`default_nettype none
`include "prio_int_regs.vh"
module prio_int_system #(
  parameter SLOTS = 4
)(
  input  wire        REF_CLK_IN,
  input  wire        ARST_N_IN,
  input  wire        PSEL_IN,
  input  wire        PENABLE_IN,
  input  wire        PWRITE_IN,
  input  wire [7:0]  PADDR_IN,
  input  wire [31:0] PWDATA_IN,
  output wire        PREADY_OUT,
  output wire        PSLVERR_OUT,
  output reg  [31:0] PRDATA_OUT,
  input  wire        INSTR_DONE_IN,
  input  wire        FETCH_CYCLE_IN,
  input  wire [1:0]  RING_IN,
  input  wire        PRIV_OP_IN,
  input  wire        MONITOR_CALL_IN,
  input  wire        PROTECT_VIOLATION_IN,
  input  wire        PAGE_FAULT_IN,
  input  wire        ILLEGAL_OP_FAULT_IN,
  input  wire        MEMORY_RANGE_FAULT_IN,
  input  wire        PARITY_FAULT_IN,
  input  wire        POWER_FAIL_EVENT_IN,
  input  wire [17:0] FAULT_ADDRESS_IN,
  input  wire [7:0]  FAULT_DETAIL_IN,
  input  wire [15:0] STATUS_ERROR_FLAGS_IN,
  input  wire        IO_TRANSFER_START_IN,
  input  wire        IO_ACK_IN,
  input  wire [3:0]  EXT_REQUEST_IN,
  input  wire [SLOTS*16-1:0] SLOT_IDENT_CODE_IN,
  input  wire [SLOTS*4-1:0]  SLOT_REQUEST_IN,
  output reg  [SLOTS-1:0]    SLOT_CLEAR_OUT,
  output reg  [3:0]  CURRENT_LEVEL_OUT,
  output reg         LEVEL_SWITCH_OUT,
  output reg         SAVE_PC_OUT,
  output reg         ABORT_INSTR_OUT,
  output reg         PC_HOLD_OUT,
  output reg         PANEL_INDICATOR_OUT
);
// ==========================================
// State
reg  [15:0] level_enable_mask;
reg  [15:0] level_request_latch;
reg  [15:0] internal_source_enable;
reg  [3:0]  internal_cause_code;
reg  [15:0] parity_fault_address;
reg  [15:0] parity_fault_status;
reg         cause_locked;
reg         fault_locked;
reg         system_on;
reg         paging_on;
reg  [15:0] ident_result;
reg         ident_valid;
reg  [15:0] prev_flags;
reg  [7:0]  io_timer;
reg         io_wait;
reg  [3:0]  pending_cause;
reg         cause_is_abort;
reg  [3:0]  next_ext_latch;

// Watchdog reload, cut to the counter width on purpose
localparam integer IO_TIMER_INT  = `IO_ACK_TIMEOUT_CYCLES - 1;
localparam [7:0]   IO_TIMER_LOAD = IO_TIMER_INT[7:0];

wire [15:0] pending_levels = level_enable_mask & level_request_latch;
wire        apb_write = PSEL_IN & PENABLE_IN & PWRITE_IN;
wire        apb_read  = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
wire        addr_ok   = (PADDR_IN <= `REG_COMMAND) && (PADDR_IN[1:0] == 2'h0);
assign PREADY_OUT  = 1'b1;
assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok;

// ==========================================
// Priority encoder, used for level choice
function [3:0] highest;
  input [15:0] v;
  integer i;
  begin
    highest = 4'h0;
    for (i = 0; i < 16; i = i + 1)
      if (v[i])
        highest = i[3:0];
  end
endfunction

wire [3:0] highest_pending_code = highest(pending_levels);
wire       level_mismatch = (highest_pending_code != CURRENT_LEVEL_OUT);

// ==========================================
// Cause selection
wire io_timeout = io_wait && (io_timer == 8'h00) && !IO_ACK_IN;
wire error_flag_rise = |(STATUS_ERROR_FLAGS_IN & ~prev_flags);
wire privileged_hit = PRIV_OP_IN && (RING_IN <= 2'h1);
always @*
begin
  pending_cause = 4'h0;
  cause_is_abort = 1'b0;
  // Only one source occurs at a time; power fail alone may overlap
  if (POWER_FAIL_EVENT_IN)
    pending_cause = `CAUSE_POWER_FAIL;
  else if (paging_on && PROTECT_VIOLATION_IN)
  begin
    pending_cause = `CAUSE_PROTECT_VIOLATION;
    cause_is_abort = 1'b1;
  end
  else if (paging_on && PAGE_FAULT_IN)
  begin
    pending_cause = `CAUSE_PAGE_FAULT;
    cause_is_abort = 1'b1;
  end
  else if (ILLEGAL_OP_FAULT_IN)
  begin
    pending_cause = `CAUSE_ILLEGAL_OP;
    cause_is_abort = 1'b1;
  end
  else if (paging_on && privileged_hit)
  begin
    pending_cause = `CAUSE_PRIVILEGED_OP;
    cause_is_abort = 1'b1;
  end
  else if (io_timeout)
  begin
    pending_cause = `CAUSE_IO_TIMEOUT;
    cause_is_abort = 1'b1;
  end
  else if (MEMORY_RANGE_FAULT_IN)
  begin
    pending_cause = `CAUSE_MEMORY_RANGE;
    cause_is_abort = 1'b1;
  end
  else if (PARITY_FAULT_IN)
    pending_cause = `CAUSE_PARITY;
  else if (MONITOR_CALL_IN)
    pending_cause = `CAUSE_MONITOR_CALL;
  else if (error_flag_rise)
    pending_cause = `CAUSE_ERROR_FLAG;
end

// Source enable bit number equals the cause code
wire source_enabled = internal_source_enable[pending_cause];
wire deliver = (pending_cause != 4'h0) && system_on && level_enable_mask[`INTERNAL_LEVEL]
               && source_enabled && (cause_is_abort || INSTR_DONE_IN) && !cause_locked;

// ==========================================
// Identify search over the I/O bus slots
reg [15:0] ident_code;
reg [SLOTS-1:0] ident_hit;
reg [1:0]  ident_lvl;
integer s;
always @*
begin
  ident_code = 16'h0000;
  ident_hit = {SLOTS{1'b0}};
  ident_lvl = PWDATA_IN[1:0];
  // Slot 0 is the leftmost, so search runs from the high index down
  for (s = SLOTS - 1; s >= 0; s = s - 1)
    if (SLOT_REQUEST_IN[s*4 + ident_lvl])
    begin
      ident_code = SLOT_IDENT_CODE_IN[s*16 +: 16];
      ident_hit = {SLOTS{1'b0}};
      ident_hit[s] = 1'b1;
    end
end
wire cmd_write = apb_write && (PADDR_IN == `REG_COMMAND);
wire ident_cmd = cmd_write && PWDATA_IN[`CMD_IDENTIFY_BIT + 4];

// External levels: software write, then give-up clear, then device sets win
always @*
begin
  next_ext_latch = level_request_latch[13:10];
  if (apb_write && PADDR_IN == `REG_LEVEL_REQUEST_LATCH)
    next_ext_latch = PWDATA_IN[13:10];
  // Levels 10..13 map to bits 0..3
  if (cmd_write && PWDATA_IN[`CMD_GIVE_UP_BIT] && (CURRENT_LEVEL_OUT >= 4'hA) && (CURRENT_LEVEL_OUT <= 4'hD))
    next_ext_latch[CURRENT_LEVEL_OUT[1:0] ^ 2'h2] = 1'b0;
  next_ext_latch = next_ext_latch | EXT_REQUEST_IN;
end

// ==========================================
// Main sequential logic
always @(posedge REF_CLK_IN or negedge ARST_N_IN)
begin
  if (!ARST_N_IN)
  begin
    level_enable_mask <= 16'h0000;
    level_request_latch <= 16'h0000;
    CURRENT_LEVEL_OUT <= 4'h0;
    internal_source_enable <= 16'h0000;
    internal_cause_code <= 4'h0;
    parity_fault_address <= 16'h0000;
    parity_fault_status <= 16'h0000;
    cause_locked <= 1'b1;
    fault_locked <= 1'b1;
    system_on <= 1'b0;
    paging_on <= 1'b0;
    ident_result <= 16'h0000;
    ident_valid <= 1'b0;
    prev_flags <= 16'h0000;
    io_timer <= 8'h00;
    io_wait <= 1'b0;
    SLOT_CLEAR_OUT <= {SLOTS{1'b0}};
    LEVEL_SWITCH_OUT <= 1'b0;
    SAVE_PC_OUT <= 1'b0;
    ABORT_INSTR_OUT <= 1'b0;
    PC_HOLD_OUT <= 1'b0;
    PANEL_INDICATOR_OUT <= 1'b0;
  end
  else
  begin
    prev_flags <= STATUS_ERROR_FLAGS_IN;
    SLOT_CLEAR_OUT <= {SLOTS{1'b0}};
    LEVEL_SWITCH_OUT <= 1'b0;
    SAVE_PC_OUT <= 1'b0;
    ABORT_INSTR_OUT <= 1'b0;
    PC_HOLD_OUT <= 1'b0;
    // I/O acknowledge watchdog
    if (IO_TRANSFER_START_IN || ident_cmd)
    begin
      io_wait <= 1'b1;
      io_timer <= IO_TIMER_LOAD;
    end
    else if (io_wait && (IO_ACK_IN || io_timer == 8'h00))
      io_wait <= 1'b0;
    else if (io_wait)
      io_timer <= io_timer - 8'h01;
    // Software writes first; hardware sets below win over clears
    if (apb_write)
    begin
      case (PADDR_IN)
        `REG_LEVEL_ENABLE_MASK:   level_enable_mask <= PWDATA_IN[15:0];
        `REG_LEVEL_REQUEST_LATCH: level_request_latch <= PWDATA_IN[15:0];
        `REG_INTERNAL_SRC_ENABLE: internal_source_enable <= PWDATA_IN[15:0];
        `REG_CONTROL:
        begin
          system_on <= PWDATA_IN[`CTRL_SYSTEM_ON_BIT];
          paging_on <= PWDATA_IN[`CTRL_PAGING_ON_BIT];
        end
        `REG_COMMAND:
        begin
          if (PWDATA_IN[`CMD_TURN_ON_BIT])
          begin
            system_on <= 1'b1;
            PANEL_INDICATOR_OUT <= 1'b1;
          end
          if (PWDATA_IN[`CMD_TURN_OFF_BIT])
          begin
            system_on <= 1'b0;
            PANEL_INDICATOR_OUT <= 1'b0;
          end
          if (PWDATA_IN[`CMD_GIVE_UP_BIT])
          begin
            level_request_latch[CURRENT_LEVEL_OUT] <= 1'b0;
            SAVE_PC_OUT <= 1'b1;
          end
          if (PWDATA_IN[`CMD_IDENTIFY_BIT + 4])
          begin
            ident_result <= ident_code;
            ident_valid <= (ident_code != 16'h0000);
            SLOT_CLEAR_OUT <= ident_hit;
          end
        end
        default:
        begin
        end
      endcase
    end
    // Reads unlock the captured registers
    if (apb_read && PADDR_IN == `REG_INTERNAL_CAUSE_CODE)
      cause_locked <= 1'b0;
    if (apb_read && PADDR_IN == `REG_PARITY_FAULT_ADDRESS)
      fault_locked <= 1'b0;
    // External device levels 10..13 latch requests
    level_request_latch[13:10] <= next_ext_latch;
    if ((pending_cause == `CAUSE_PARITY || pending_cause == `CAUSE_MEMORY_RANGE) && !fault_locked)
    begin
      parity_fault_address <= FAULT_ADDRESS_IN[15:0];
      parity_fault_status <= {6'h00, FAULT_DETAIL_IN, FAULT_ADDRESS_IN[17:16]};
      fault_locked <= 1'b1;
    end
    if (deliver)
    begin
      internal_cause_code <= pending_cause;
      cause_locked <= 1'b1;
      level_request_latch[`INTERNAL_LEVEL] <= 1'b1;
      ABORT_INSTR_OUT <= cause_is_abort;
      PC_HOLD_OUT <= FETCH_CYCLE_IN && (pending_cause == `CAUSE_MEMORY_RANGE ||
                     pending_cause == `CAUSE_PAGE_FAULT || pending_cause == `CAUSE_PROTECT_VIOLATION);
    end
    // Level change at an instruction boundary while switching is on
    if (system_on && INSTR_DONE_IN && level_mismatch)
    begin
      CURRENT_LEVEL_OUT <= highest_pending_code;
      LEVEL_SWITCH_OUT <= 1'b1;
      SAVE_PC_OUT <= 1'b1;
    end
  end
end

// ==========================================
// Read data, registered during the setup phase
always @(posedge REF_CLK_IN or negedge ARST_N_IN)
begin
  if (!ARST_N_IN)
    PRDATA_OUT <= 32'h00000000;
  else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
  begin
    case (PADDR_IN)
      `REG_LEVEL_ENABLE_MASK:    PRDATA_OUT <= {16'h0000, level_enable_mask};
      `REG_LEVEL_REQUEST_LATCH:  PRDATA_OUT <= {16'h0000, level_request_latch};
      `REG_CURRENT_LEVEL:        PRDATA_OUT <= {28'h0000000, CURRENT_LEVEL_OUT};
      `REG_INTERNAL_SRC_ENABLE:  PRDATA_OUT <= {16'h0000, internal_source_enable};
      `REG_INTERNAL_CAUSE_CODE:  PRDATA_OUT <= {28'h0000000, internal_cause_code};
      `REG_PARITY_FAULT_ADDRESS: PRDATA_OUT <= {16'h0000, parity_fault_address};
      `REG_PARITY_FAULT_STATUS:  PRDATA_OUT <= {16'h0000, parity_fault_status};
      `REG_CONTROL:              PRDATA_OUT <= {30'h00000000, paging_on, system_on};
      `REG_STATUS:               PRDATA_OUT <= {16'h0000, io_wait, ident_valid, fault_locked, cause_locked,
                                                8'h00, highest_pending_code};
      `REG_IDENT_RESULT:         PRDATA_OUT <= {16'h0000, ident_result};
      default:                   PRDATA_OUT <= 32'h00000000;
    endcase
  end
end
endmodule
`default_nettype wire
